// file: core/dcu_pkg.sv
package dcu_pkg;
    // command bytes
    localparam logic [7:0] CMD_REV_RD = 8'h00;
    localparam logic [7:0] CMD_CNT_WR = 8'h01;
    localparam logic [7:0] CMD_STAT_RD = 8'h02;
    localparam logic [7:0] CMD_CNT_RD = 8'h03;
    localparam logic [7:0] CMD_CTL_WR = 8'h04;
    localparam logic [7:0] CMD_CTL_RD = 8'h05;
    localparam logic [7:0] CMD_PC_WR = 8'h06;
    localparam logic [7:0] CMD_PC_RD = 8'h07;
    localparam logic [7:0] CMD_REG_WR = 8'h08;
    localparam logic [7:0] CMD_REG_RD = 8'h09;
    localparam logic [7:0] CMD_PM_WR = 8'h0A;
    localparam logic [7:0] CMD_PM_RD = 8'h0B;
    localparam logic [7:0] CMD_DM_WR = 8'h0C;
    localparam logic [7:0] CMD_DM_RD = 8'h0D;
    localparam logic [7:0] CMD_CRC_RD = 8'h0E;
    localparam logic [7:0] CMD_RSVD = 8'h0F;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    // debugger_control fields
    localparam int CTL_HALT = 7;
    localparam int CTL_BRK_ALLOW = 6;
    localparam int CTL_ACK_EN = 5;
    localparam int CTL_SPIN = 4;
    localparam int CTL_PC_MATCH = 3;
    localparam int CTL_ZERO_BRK = 2;
    localparam int CTL_RST = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hFD;
    localparam logic [7:0] CTL_RESET_HALT = 8'h81;
    localparam logic [7:0] CTL_RESET_RUN = 8'h41;
    // fixed byte, word and nibble values
    localparam logic [7:0] ACK_CHAR = 8'hFF;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [15:0] FILL_WORD = 16'hFFFF;
    localparam logic [3:0] ADDR_HI_PAD = 4'h0;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
endpackage

// file: core/dcu_ctrl.sv
`timescale 1ns/100ps
module dcu_ctrl
    import dcu_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic protect,
    input wire logic brk_hit,
    input wire logic pc_equal,
    output logic [7:0] ctl,
    output logic cpu_reset,
    output logic brk_spin,
    output logic brk_event
);
    logic [7:0] ctl_reg, ctl_next;
    logic rst_reg, rst_next, spin_reg, spin_next, ev_reg, ev_next;
    logic breakpoint_opcode, pcm;

    always_comb
    begin
        ctl_next = ctl_reg;
        rst_next = 1'b0;
        breakpoint_opcode = brk_hit && ctl_reg[CTL_BRK_ALLOW];
        pcm = pc_equal && ctl_reg[CTL_PC_MATCH] && !ctl_reg[CTL_HALT];
        if (ctl_wr)
        begin
            ctl_next = ctl_wdata & CTL_WMASK;
            ctl_next[CTL_RST] = 1'b0;
            rst_next = ctl_wdata[CTL_RST];
            if (protect && ctl_reg[CTL_HALT])
                ctl_next[CTL_HALT] = 1'b1;
        end
        // breakpoint set wins over a software clear in the same cycle
        if (breakpoint_opcode && !ctl_reg[CTL_SPIN])
            ctl_next[CTL_HALT] = 1'b1;
        if (pcm)
            ctl_next[CTL_HALT] = 1'b1;
        spin_next = breakpoint_opcode && ctl_reg[CTL_SPIN];
        ev_next = (breakpoint_opcode || pcm) && ctl_reg[CTL_ACK_EN];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctl_reg <= CTL_RESET;
            rst_reg <= 1'b0;
            spin_reg <= 1'b0;
            ev_reg <= 1'b0;
        end
        else
        begin
            ctl_reg <= ctl_next;
            rst_reg <= rst_next;
            spin_reg <= spin_next;
            ev_reg <= ev_next;
        end
    end

    assign ctl = ctl_reg;
    assign cpu_reset = rst_reg;
    assign brk_spin = spin_reg;
    assign brk_event = ev_reg;

    sequence s_reset_halt;
        ctl_wr && ctl_wdata == CTL_RESET_HALT;
    endsequence

    AST_RESET_HALT: assert property (@(posedge clk) disable iff (!reset_n)
        s_reset_halt |=> cpu_reset && ctl[CTL_HALT])
        else $error("reset-and-halt write did not reset and halt");
    AST_PROTECT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        protect && ctl[CTL_HALT] |=> ctl[CTL_HALT])
        else $error("halt bit cleared under read protection");
    AST_BRK_HALT: assert property (@(posedge clk) disable iff (!reset_n)
        brk_hit && ctl[CTL_BRK_ALLOW] && !ctl[CTL_SPIN] |=> ctl[CTL_HALT])
        else $error("breakpoint did not enter halt");
    AST_BRK_NOP: assert property (@(posedge clk) disable iff (!reset_n)
        !ctl[CTL_BRK_ALLOW] |=> !brk_spin)
        else $error("breakpoint acted while disabled");
    AST_ACK: assert property (@(posedge clk) disable iff (!reset_n)
        brk_hit && ctl[CTL_BRK_ALLOW] && ctl[CTL_ACK_EN] |=> brk_event)
        else $error("breakpoint acknowledge missing");
    AST_PC_BREAK: assert property (@(posedge clk) disable iff (!reset_n)
        pc_equal && ctl[CTL_PC_MATCH] && !ctl[CTL_HALT] |=> ctl[CTL_HALT])
        else $error("counter match did not halt");
endmodule

// file: core/dcu_top.sv
// What this block does
// - Command byte selects the operation; 0FH is reserved and ignored.
// - Outside halt only revision, status and control commands act.
// - Control write takes one value byte; control read returns it.
// - Counter write takes high then low byte; dropped unless halted; protection does not block it.
// - Counter read returns high, low; all ones unless halted; protection does not block it.
// - Register write: address high, address low, size, data; size 0 is 256.
// - Register writes dropped outside halt; protected: flash mass erase only.
// - Register read returns size bytes; all ones unless halted, unprotected.
// - Debugger reads suppress side effects except watchdog status.
// - Protection disables program counter, memory, step and stuff commands.
// - 81H resets and halts, 41H resets and runs, 40H resumes.
// - Bit 7 halts; under protection it cannot be cleared by writing.
// - Bit 6 enables breakpoints; otherwise the opcode is a no-op.
// - Bit 5 sends an all-ones acknowledge on every breakpoint.
// - Bit 4 zero halts on breakpoint; one makes the CPU spin.
// - Bit 3 breaks when program counter equals debugger_counter.
`timescale 1ns/100ps
module dcu_top
    import dcu_pkg::*;
#(
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter logic [11:0] FLASH_CTL_ADDR = 12'hFF0,
    parameter logic [7:0] MASS_ERASE_CODE = 8'hAA,
    parameter logic [11:0] WDT_STAT_ADDR = 12'hFF1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic read_protect,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] crc_value,
    input wire logic brk_decoded,
    input wire logic [7:0] reg_rdata,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_quiet,
    output logic pc_wr,
    output logic [15:0] pc_wdata,
    output logic step,
    output logic stuff,
    output logic [7:0] stuff_byte,
    output logic halt,
    output logic cpu_reset,
    output logic brk_spin,
    output logic [7:0] debugger_control
);
    typedef enum logic [6:0] {
        ST_CMD = 7'b000_0001,
        ST_OPND = 7'b000_0010,
        ST_WDATA = 7'b000_0100,
        ST_RDREQ = 7'b000_1000,
        ST_RDCAP = 7'b001_0000,
        ST_SEND = 7'b010_0000,
        ST_SPARE = 7'b100_0000
    } dcu_state_e;

    function automatic logic dcu_cmd_ok(input logic [7:0] c,
                                        input logic dbg,
                                        input logic prot);
        logic open_cmd;
        logic guarded;
        open_cmd = c inside {CMD_REV_RD, CMD_STAT_RD, CMD_CTL_WR, CMD_CTL_RD};
        guarded = c inside {CMD_PC_WR, CMD_PC_RD, CMD_PM_WR, CMD_PM_RD,
                            CMD_DM_WR, CMD_DM_RD, CMD_STEP, CMD_STUFF};
        dcu_cmd_ok = open_cmd || (dbg && !(prot && guarded));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // protect strap synchroniser and control register
    logic prot_s1_reg, prot_s2_reg;
    logic [7:0] ctl;
    logic ctl_wr_reg, ctl_wr_next;
    logic [7:0] ctl_wdata_reg, ctl_wdata_next;
    logic brk_event, dbg, prot;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prot_s1_reg <= 1'b0;
            prot_s2_reg <= 1'b0;
        end
        else
        begin
            prot_s1_reg <= read_protect;
            prot_s2_reg <= prot_s1_reg;
        end
    end

    assign prot = prot_s2_reg;
    assign dbg = ctl[CTL_HALT];

    logic [15:0] counter_reg, counter_next;

    dcu_ctrl u_ctrl (
        .clk(clk),
        .reset_n(reset_n),
        .ctl_wr(ctl_wr_reg),
        .ctl_wdata(ctl_wdata_reg),
        .protect(prot),
        .brk_hit(brk_decoded),
        .pc_equal(cpu_pc == counter_reg),
        .ctl(ctl),
        .cpu_reset(cpu_reset),
        .brk_spin(brk_spin),
        .brk_event(brk_event)
    );

    ////////////////////////////////////////////////////////////////////////
    // command interpreter
    dcu_state_e state_reg, state_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [23:0] opnd_reg, opnd_next;
    logic [1:0] ocnt_reg, ocnt_next;
    logic [11:0] addr_reg, addr_next;
    logic [8:0] len_reg, len_next;
    logic [15:0] buf_reg, buf_next;
    logic [1:0] tcnt_reg, tcnt_next;
    logic ack_reg, ack_next;
    logic tx_valid_reg, tx_valid_next;
    logic [7:0] tx_byte_reg, tx_byte_next;
    logic [11:0] reg_addr_reg, reg_addr_next;
    logic [7:0] reg_wdata_reg, reg_wdata_next;
    logic reg_wr_reg, reg_wr_next, reg_rd_reg, reg_rd_next;
    logic reg_quiet_reg, reg_quiet_next;
    logic pc_wr_reg, pc_wr_next;
    logic [15:0] pc_wdata_reg, pc_wdata_next;
    logic step_reg, step_next, stuff_reg, stuff_next;
    logic [7:0] stuff_byte_reg, stuff_byte_next;
    logic ok, rd_ok;
    logic [23:0] o;

    always_comb
    begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        opnd_next = opnd_reg;
        ocnt_next = ocnt_reg;
        addr_next = addr_reg;
        len_next = len_reg;
        buf_next = buf_reg;
        tcnt_next = tcnt_reg;
        ack_next = ack_reg;
        counter_next = counter_reg;
        tx_valid_next = 1'b0;
        tx_byte_next = tx_byte_reg;
        reg_addr_next = reg_addr_reg;
        reg_wdata_next = reg_wdata_reg;
        reg_quiet_next = reg_quiet_reg;
        pc_wdata_next = pc_wdata_reg;
        stuff_byte_next = stuff_byte_reg;
        reg_wr_next = 1'b0;
        reg_rd_next = 1'b0;
        pc_wr_next = 1'b0;
        step_next = 1'b0;
        stuff_next = 1'b0;
        ctl_wr_next = 1'b0;
        ctl_wdata_next = ctl_wdata_reg;
        o = {opnd_reg[15:0], rx_byte};
        rd_ok = dbg && !prot;
        ok = dcu_cmd_ok(cmd_reg, dbg, prot);
        unique case (state_reg)
            ST_CMD:
            begin
                ok = dcu_cmd_ok(rx_byte, dbg, prot);
                if (rx_valid)
                begin
                    cmd_next = rx_byte;
                    tcnt_next = 2'd1;
                    state_next = ST_SEND;
                    unique case (rx_byte)
                        CMD_REV_RD: buf_next = {REVISION, 8'h00};
                        CMD_STAT_RD: buf_next = {dbg, prot, 6'h00, 8'h00};
                        CMD_CTL_RD: buf_next = {ctl, 8'h00};
                        CMD_CNT_RD:
                        begin
                            buf_next = ok ? counter_reg : FILL_WORD;
                            tcnt_next = 2'd2;
                        end
                        CMD_PC_RD:
                        begin
                            buf_next = ok ? cpu_pc : FILL_WORD;
                            tcnt_next = 2'd2;
                        end
                        CMD_CRC_RD:
                        begin
                            buf_next = ok ? crc_value : FILL_WORD;
                            tcnt_next = 2'd2;
                        end
                        CMD_CNT_WR, CMD_PC_WR:
                        begin
                            ocnt_next = 2'd2;
                            state_next = ST_OPND;
                        end
                        CMD_CTL_WR, CMD_STUFF:
                        begin
                            ocnt_next = 2'd1;
                            state_next = ST_OPND;
                        end
                        CMD_REG_WR, CMD_REG_RD:
                        begin
                            ocnt_next = 2'd3;
                            state_next = ST_OPND;
                        end
                        CMD_STEP:
                        begin
                            step_next = ok;
                            state_next = ST_CMD;
                        end
                        default: state_next = ST_CMD;
                    endcase
                end
                else if (ack_reg)
                begin
                    buf_next = {ACK_CHAR, 8'h00};
                    tcnt_next = 2'd1;
                    cmd_next = CMD_REV_RD;
                    ack_next = 1'b0;
                    state_next = ST_SEND;
                end
            end
            ST_OPND:
            begin
                if (rx_valid)
                begin
                    opnd_next = o;
                    ocnt_next = ocnt_reg - 2'd1;
                    if (ocnt_reg == 2'd1)
                    begin
                        state_next = ST_CMD;
                        unique case (cmd_reg)
                            CMD_CNT_WR:
                                if (ok)
                                    counter_next = o[15:0];
                            CMD_PC_WR:
                            begin
                                pc_wr_next = ok;
                                pc_wdata_next = o[15:0];
                            end
                            CMD_CTL_WR:
                            begin
                                ctl_wr_next = 1'b1;
                                ctl_wdata_next = o[7:0];
                            end
                            CMD_STUFF:
                            begin
                                stuff_next = ok;
                                stuff_byte_next = o[7:0];
                            end
                            default:
                            begin
                                addr_next = {o[19:16], o[15:8]};
                                len_next = {o[7:0] == 8'h00, o[7:0]};
                                state_next = (cmd_reg == CMD_REG_WR) ?
                                    ST_WDATA : ST_RDREQ;
                            end
                        endcase
                    end
                end
            end
            ST_WDATA:
            begin
                if (rx_valid)
                begin
                    reg_wr_next = dbg && (!prot ||
                        (addr_reg == FLASH_CTL_ADDR &&
                         rx_byte == MASS_ERASE_CODE));
                    reg_addr_next = addr_reg;
                    reg_wdata_next = rx_byte;
                    addr_next = addr_reg + 12'h001;
                    len_next = len_reg - 9'h001;
                    if (len_reg == 9'h001)
                        state_next = ST_CMD;
                end
            end
            ST_RDREQ:
            begin
                tcnt_next = 2'd1;
                if (rd_ok)
                begin
                    reg_rd_next = 1'b1;
                    reg_addr_next = addr_reg;
                    reg_quiet_next = addr_reg != WDT_STAT_ADDR;
                    state_next = ST_RDCAP;
                end
                else
                begin
                    buf_next = {FILL_BYTE, 8'h00};
                    state_next = ST_SEND;
                end
            end
            ST_RDCAP:
            begin
                buf_next = {reg_rdata, 8'h00};
                state_next = ST_SEND;
            end
            ST_SEND:
            begin
                tx_valid_next = 1'b1;
                tx_byte_next = buf_reg[15:8];
                if (tx_valid_reg && tx_ready)
                begin
                    buf_next = {buf_reg[7:0], 8'h00};
                    tcnt_next = tcnt_reg - 2'd1;
                    tx_byte_next = buf_reg[7:0];
                    if (tcnt_reg == 2'd1)
                    begin
                        tx_valid_next = 1'b0;
                        state_next = ST_CMD;
                        if (cmd_reg == CMD_REG_RD)
                        begin
                            addr_next = addr_reg + 12'h001;
                            len_next = len_reg - 9'h001;
                            if (len_reg != 9'h001)
                                state_next = ST_RDREQ;
                        end
                    end
                end
            end
            default: state_next = ST_CMD;
        endcase
        if (brk_event)
            ack_next = 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_CMD;
            cmd_reg <= CMD_REV_RD;
            opnd_reg <= 24'h00_0000;
            ocnt_reg <= 2'd0;
            addr_reg <= 12'h000;
            len_reg <= 9'h000;
            buf_reg <= 16'h0000;
            tcnt_reg <= 2'd0;
            ack_reg <= 1'b0;
            counter_reg <= COUNTER_RESET;
            tx_valid_reg <= 1'b0;
            tx_byte_reg <= 8'h00;
            reg_addr_reg <= 12'h000;
            reg_wdata_reg <= 8'h00;
            reg_wr_reg <= 1'b0;
            reg_rd_reg <= 1'b0;
            reg_quiet_reg <= 1'b0;
            pc_wr_reg <= 1'b0;
            pc_wdata_reg <= 16'h0000;
            step_reg <= 1'b0;
            stuff_reg <= 1'b0;
            stuff_byte_reg <= 8'h00;
            ctl_wr_reg <= 1'b0;
            ctl_wdata_reg <= CTL_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            opnd_reg <= opnd_next;
            ocnt_reg <= ocnt_next;
            addr_reg <= addr_next;
            len_reg <= len_next;
            buf_reg <= buf_next;
            tcnt_reg <= tcnt_next;
            ack_reg <= ack_next;
            counter_reg <= counter_next;
            tx_valid_reg <= tx_valid_next;
            tx_byte_reg <= tx_byte_next;
            reg_addr_reg <= reg_addr_next;
            reg_wdata_reg <= reg_wdata_next;
            reg_wr_reg <= reg_wr_next;
            reg_rd_reg <= reg_rd_next;
            reg_quiet_reg <= reg_quiet_next;
            pc_wr_reg <= pc_wr_next;
            pc_wdata_reg <= pc_wdata_next;
            step_reg <= step_next;
            stuff_reg <= stuff_next;
            stuff_byte_reg <= stuff_byte_next;
            ctl_wr_reg <= ctl_wr_next;
            ctl_wdata_reg <= ctl_wdata_next;
        end
    end

    assign tx_valid = tx_valid_reg;
    assign tx_byte = tx_byte_reg;
    assign reg_addr = reg_addr_reg;
    assign reg_wdata = reg_wdata_reg;
    assign reg_wr = reg_wr_reg;
    assign reg_rd = reg_rd_reg;
    assign reg_quiet = reg_quiet_reg;
    assign pc_wr = pc_wr_reg;
    assign pc_wdata = pc_wdata_reg;
    assign step = step_reg;
    assign stuff = stuff_reg;
    assign stuff_byte = stuff_byte_reg;
    assign halt = ctl[CTL_HALT];
    assign debugger_control = ctl;

    AST_PC_WR_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        pc_wr |-> $past(dbg) && !$past(prot))
        else $error("counter write passed while not allowed");
    AST_REG_WR_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr |-> $past(dbg) && (!$past(prot) ||
            (reg_addr == FLASH_CTL_ADDR && reg_wdata == MASS_ERASE_CODE)))
        else $error("register write passed while not allowed");
    AST_REG_RD_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd |-> $past(dbg) && !$past(prot))
        else $error("register read issued while not allowed");
    AST_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr != WDT_STAT_ADDR |-> reg_quiet)
        else $error("debugger read not marked side-effect free");
    AST_STEP_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        step || stuff |-> !$past(prot) && $past(dbg))
        else $error("step or stuff while refused");
    AST_COUNTER_GATE: assert property (@(posedge clk) disable iff (!reset_n)
        counter_reg != $past(counter_reg) |-> $past(dbg))
        else $error("counter changed outside halt");
    AST_PC_RD_FILL: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_CMD && rx_valid && rx_byte == CMD_PC_RD &&
        !(dbg && !prot) |=> buf_reg == FILL_WORD)
        else $error("refused counter read not all ones");
    AST_SEND_BOUND: assert property (@(posedge clk) disable iff (!reset_n)
        state_reg == ST_CMD && rx_valid && rx_byte == CMD_CTL_RD
        |=> ##1 tx_valid && tx_byte == $past(ctl, 2))
        else $error("control read did not return control value");
endmodule

// file: tb/dcu_host.sv
`timescale 1ns/100ps
module dcu_host
    import dcu_pkg::*;
(
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    initial
    begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // one byte per pulse; the idle line shows the inverse of the last byte
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_byte = b;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_byte = ~b;
    endtask
    // stalls for slow cycles before accepting a byte
    task automatic recv(input int slow, output logic [7:0] b);
        int n;
        for (n = 0; n < 40 && tx_valid !== 1'b1; n++)
            @(negedge clk);
        repeat (slow) @(negedge clk);
        tx_ready = 1'b1;
        b = tx_byte;
        @(negedge clk);
        tx_ready = 1'b0;
    endtask
endmodule

// file: tb/dcu_top_tb.sv
`timescale 1ns/100ps
module dcu_top_tb;
    import dcu_pkg::*;
    logic clk, reset_n, rx_valid, tx_ready, tx_valid, read_protect;
    logic brk_decoded, reg_wr, reg_rd, pc_wr, halt, cpu_reset, step;
    logic [7:0] rx_byte, tx_byte, reg_wdata, debugger_control;
    logic [11:0] reg_addr;
    logic [15:0] cpu_pc, pc_wdata, pc_seen, v;
    logic [19:0] wr_seen;
    int err_count, checked, rst_cnt, cycles, step_cnt;
    dcu_top u_dcu_top (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .read_protect(read_protect), .cpu_pc(cpu_pc),
        .crc_value(16'h0000), .brk_decoded(brk_decoded),
        .reg_rdata(reg_addr[7:0] ^ 8'h5A), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_quiet(), .pc_wr(pc_wr), .pc_wdata(pc_wdata), .step(step),
        .stuff(), .stuff_byte(), .halt(halt), .cpu_reset(cpu_reset),
        .brk_spin(), .debugger_control(debugger_control));
    dcu_host u_dcu_host (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (pc_wr === 1'b1)
            pc_seen <= pc_wdata;
        if (reg_wr === 1'b1)
            wr_seen <= {reg_addr, reg_wdata};
        if (cpu_reset === 1'b1)
            rst_cnt <= rst_cnt + 1;
        if (step === 1'b1)
            step_cnt <= step_cnt + 1;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic h(input logic [7:0] b);
        u_dcu_host.send(b);
        // let registered strobes reach the monitors before any compare
        @(negedge clk);
    endtask
    task automatic get(input int n, output logic [15:0] r);
        logic [7:0] b;
        r = 16'h0000;
        repeat (n)
        begin
            u_dcu_host.recv(n, b);
            r = {r[7:0], b};
        end
    endtask
    task automatic hdr(input logic [7:0] c, input logic [11:0] a);
        h(c);
        h({ADDR_HI_PAD, a[11:8]});
        h(a[7:0]);
    endtask
    task automatic cw(input logic [7:0] b);
        h(CMD_CTL_WR);
        h(b);
        repeat (3) @(negedge clk);
    endtask
    initial
    begin
        {reset_n, read_protect, brk_decoded} = 3'b000;
        {err_count, checked, rst_cnt, cycles, step_cnt} = '0;
        {cpu_pc, pc_seen, wr_seen} = {16'h1234, 16'h0000, 20'h0_0000};
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        cmp(debugger_control, CTL_RESET);
        h(CMD_CTL_RD);
        get(1, v);
        cmp(v, 16'h0000);
        h(CMD_PC_RD);
        get(2, v);
        cmp(v, FILL_WORD);
        hdr(CMD_REG_RD, 12'h010);
        h(8'h01);
        get(1, v);
        cmp(v, 16'h00FF);
        hdr(CMD_REG_WR, 12'h010);
        h(8'h01);
        h(8'hAA);
        cmp(wr_seen, 20'h0_0000);
        cw(CTL_RESET_HALT);
        cmp(rst_cnt, 1);
        cmp(halt, 1'b1);
        h(CMD_CTL_RD);
        get(1, v);
        cmp(v, 16'h0080);
        h(CMD_PC_RD);
        get(2, v);
        cmp(v, 16'h1234);
        h(CMD_PC_WR);
        h(8'h56);
        h(8'h78);
        cmp(pc_seen, 16'h5678);
        hdr(CMD_REG_WR, 12'h012);
        h(8'h01);
        h(8'h3C);
        cmp(wr_seen, 20'h0_123C);
        hdr(CMD_REG_RD, 12'h020);
        h(8'h02);
        get(2, v);
        cmp(v, 16'h7A7B);
        h(CMD_CNT_WR);
        h(8'h43);
        h(8'h21);
        h(CMD_CNT_RD);
        get(2, v);
        cmp(v, 16'h4321);
        h(CMD_STEP);
        cmp(step_cnt, 1);
        cw(8'h40);
        cmp(halt, 1'b0);
        cpu_pc = 16'h4321;
        cw(8'h08);
        cmp(halt, 1'b1);
        cw(8'h40);
        cmp(halt, 1'b0);
        cw(8'h60);
        @(negedge clk) brk_decoded = 1'b1;
        @(negedge clk) brk_decoded = 1'b0;
        cmp(halt, 1'b1);
        get(1, v);
        cmp(v, 16'h00FF);
        read_protect = 1'b1;
        cw(8'h00);
        cmp(halt, 1'b1);
        h(CMD_PC_RD);
        get(2, v);
        cmp(v, FILL_WORD);
        conclude();
    end
endmodule
